// file: ats_sequencer.sv
// Summary of operation
// - Selector 2 with enable and run starts rotating test.
// - Rotating test drives rated current, two electrical turns.
// - Without sensorless, phase angle from selected feedback.
// - Then standstill measurement of resistance, inductance, offsets, Lq.
// - Current gains computed once per test only.
// - After 5 s, one more turn, eight cogging values.
// - Selector 3 with enable and run starts inertia test.
// - Ramp to quarter speed, hold 60 s, store inertia.
// - Speed missed on last attempt aborts with trip.
// - After any test, inhibit until controlled disable.
// - Selector 4 with enable and run starts locked-rotor test.
// - Gain-set selector 0 uses set one, 1 set two.
// - Gain-set selector may change at any time.
// - Method 1 computes speed gains from bandwidth, damping, inertia.
// - Method 2 computes speed gains from compliance angle.
// - Method 3 multiplies selected proportional gain by 16.
// - Methods 4-6 load set one at 5/25/100 Hz.
//
// The APB interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "ats_params.svh"
module ats_sequencer #(
	parameter int unsigned COG_WAIT_CYC = `ATS_COG_WAIT_S * `ATS_CLK_HZ,
	parameter int unsigned INR_HOLD_CYC = `ATS_INR_HOLD_S * `ATS_CLK_HZ,
	parameter int unsigned RAMP_TMO_CYC = `ATS_RAMP_TMO_S * `ATS_CLK_HZ,
	parameter int unsigned INR_TRIES    = `ATS_INR_TRIES
) (
	// Clock and reset.
	input  wire logic        i_clock,
	input  wire logic        i_rst_n,
	// APB slave.
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	// Pins from the terminals and the encoder.
	input  wire logic        i_enable_pin,
	input  wire logic        i_run_pin,
	input  wire logic        i_elec_rev_pin,
	// Measurement engine on the same clock.
	input  wire logic        i_meas_valid,
	input  wire logic [4:0]  i_meas_idx,
	input  wire logic [15:0] i_meas_data,
	input  wire logic        i_meas_done,
	input  wire logic        i_at_speed,
	input  wire logic [15:0] i_fb_angle0,
	input  wire logic [15:0] i_fb_angle1,
	// Power stage and speed loop commands.
	output logic             o_rated_current,
	output logic             o_rotate,
	output logic             o_direction,
	output logic             o_ramp_run,
	output logic      [15:0] o_speed_target,
	output logic             o_meas_req,
	output logic      [1:0]  o_meas_kind,
	output logic             o_trip,
	output logic             o_inhibit,
	output logic             o_run_allow,
	output logic      [19:0] o_kp_active,
	output logic      [15:0] o_ki_active,
	output logic      [15:0] o_cur_kp,
	output logic      [15:0] o_cur_ki,
	output logic      [15:0] o_phase_angle
);
	ats_pkg::ats_state_t st_q, st_d;
	ats_pkg::ats_word_t  res_q [`ATS_RES_N];
	ats_pkg::ats_word_t  res_d [`ATS_RES_N];
	ats_pkg::ats_word_t  rspd_q, rspd_d, kp1_q, kp1_d, ki1_q, ki1_d, kp2_q, kp2_d;
	ats_pkg::ats_word_t  ki2_q, ki2_d, bw_q, bw_d, ang_q, ang_d, damp_q, damp_d;
	ats_pkg::ats_word_t  iner_q, iner_d, ckp_q, ckp_d, cki_q, cki_d, ph_q, ph_d;
	logic [11:0] ctrl_q, ctrl_d;
	logic [31:0] cnt_q, cnt_d, prdata_d;
	logic [3:0]  revs_q, revs_d, samp_q, samp_d;
	logic [7:0]  tries_q, tries_d;
	logic        cal_q, cal_d, rdy_q, rdy_d, err_q, err_d;
	logic [2:0]  en_sync_q, run_sync_q;
	logic [2:0]  rev_sync_q;
	logic        rated_d, rotate_d, ramp_d, mreq_d, trip_d, inh_d, allow_d;
	logic [1:0]  kind_d;
	logic [19:0] kpa_d;
	logic [15:0] bwv, dmv;
	logic [31:0] jb;
	logic [47:0] pk, pi;
	logic [5:0]  widx;
	logic        acc, hit, dis, go, rev_pulse, en_s, run_s;
	logic [2:0]  sel, sm;

	// Pins pass two flops; the third stage of the encoder line feeds only the edge detector.
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			en_sync_q  <= 3'h0;
			run_sync_q <= 3'h0;
			rev_sync_q <= 3'h0;
		end else begin
			en_sync_q  <= {en_sync_q[1:0], i_enable_pin};
			run_sync_q <= {run_sync_q[1:0], i_run_pin};
			rev_sync_q <= {rev_sync_q[1:0], i_elec_rev_pin};
		end
	end

	// Next values for the register file, the sequencer and the registered outputs.
	always_comb begin
		st_d = st_q; cnt_d = cnt_q; revs_d = revs_q; samp_d = samp_q; tries_d = tries_q;
		cal_d = cal_q; ctrl_d = ctrl_q; rspd_d = rspd_q; kp1_d = kp1_q; ki1_d = ki1_q;
		kp2_d = kp2_q; ki2_d = ki2_q; bw_d = bw_q; ang_d = ang_q; damp_d = damp_q;
		iner_d = iner_q; ckp_d = ckp_q; cki_d = cki_q; ph_d = ph_q;
		res_d = res_q;
		en_s = en_sync_q[1];
		run_s = run_sync_q[1];
		rev_pulse = rev_sync_q[1] & ~rev_sync_q[2];
		sel = ctrl_q[`ATS_F_SEL];
		sm = ctrl_q[`ATS_F_SM];
		// Any of the three disable paths counts as a controlled disable.
		dis = ~en_s | ~ctrl_q[`ATS_F_EN] | ctrl_q[`ATS_F_CWDIS];
		go = run_s & ~dis;
		// APB: one wait state, the write lands at the edge where pready is high.
		acc = i_psel & i_penable & rdy_q;
		rdy_d = i_psel & i_penable & ~rdy_q;
		widx = i_paddr[7:2] - `ATS_RES_W_LO;
		hit = 1'b1;
		prdata_d = 32'h0;
		case (i_paddr)
			`ATS_A_CTRL:  prdata_d = {20'h0, ctrl_q};
			`ATS_A_STAT:  prdata_d = {16'h0, tries_q, 1'b0, cal_q, st_q == ats_pkg::ST_TRIP,
				st_q == ats_pkg::ST_INHIBIT, st_q};
			`ATS_A_RSPD:  prdata_d = {16'h0, rspd_q};
			`ATS_A_KP1:   prdata_d = {16'h0, kp1_q};
			`ATS_A_KI1:   prdata_d = {16'h0, ki1_q};
			`ATS_A_KP2:   prdata_d = {16'h0, kp2_q};
			`ATS_A_KI2:   prdata_d = {16'h0, ki2_q};
			`ATS_A_BW:    prdata_d = {16'h0, bw_q};
			`ATS_A_ANG:   prdata_d = {16'h0, ang_q};
			`ATS_A_DAMP:  prdata_d = {16'h0, damp_q};
			`ATS_A_INER:  prdata_d = {16'h0, iner_q};
			`ATS_A_CKP:   prdata_d = {16'h0, ckp_q};
			`ATS_A_CKI:   prdata_d = {16'h0, cki_q};
			`ATS_A_PHASE: prdata_d = {16'h0, ph_q};
			default: begin
				if (i_paddr[1:0] == 2'h0 && i_paddr[7:2] >= `ATS_RES_W_LO &&
					i_paddr[7:2] < `ATS_RES_W_HI) begin
					prdata_d = {16'h0, res_q[widx[4:0]]};
				end else begin
					hit = 1'b0;
				end
			end
		endcase
		if (!i_psel) begin
			prdata_d = 32'h0;
		end
		err_d = rdy_d & ~hit;
		// The gain-set selector is an ordinary field, writable in any state.
		if (acc && i_pwrite) begin
			case (i_paddr)
				`ATS_A_CTRL: ctrl_d = i_pwdata[11:0];
				`ATS_A_RSPD: rspd_d = i_pwdata[15:0];
				`ATS_A_KP1:  kp1_d = i_pwdata[15:0];
				`ATS_A_KI1:  ki1_d = i_pwdata[15:0];
				`ATS_A_KP2:  kp2_d = i_pwdata[15:0];
				`ATS_A_KI2:  ki2_d = i_pwdata[15:0];
				`ATS_A_BW:   bw_d = i_pwdata[15:0];
				`ATS_A_ANG:  ang_d = i_pwdata[15:0];
				`ATS_A_DAMP: damp_d = i_pwdata[15:0];
				`ATS_A_INER: iner_d = i_pwdata[15:0];
				`ATS_A_CKP:  ckp_d = i_pwdata[15:0];
				`ATS_A_CKI:  cki_d = i_pwdata[15:0];
				default: ;
			endcase
		end
		// Measured values land after software writes, so the engine wins a collision.
		if (i_meas_valid && i_meas_idx < 5'(`ATS_RES_N)) begin
			res_d[i_meas_idx] = i_meas_data;
			if (i_meas_idx == `ATS_RES_INER) begin
				iner_d = i_meas_data;
			end
		end
		// Bandwidth based gains share one multiplier across methods 1 and 4 to 6.
		bwv = bw_q;
		dmv = damp_q;
		case (sm)
			`ATS_SM_LOW:  begin bwv = `ATS_BW_LOW;  dmv = `ATS_DAMP_UNITY; end
			`ATS_SM_STD:  begin bwv = `ATS_BW_STD;  dmv = `ATS_DAMP_UNITY; end
			`ATS_SM_HIGH: begin bwv = `ATS_BW_HIGH; dmv = `ATS_DAMP_UNITY; end
			default: ;
		endcase
		jb = iner_q * bwv;
		pk = 48'(jb) * 48'(dmv);
		pi = 48'(jb) * 48'(bwv);
		case (sm)
			`ATS_SM_BW, `ATS_SM_LOW, `ATS_SM_STD, `ATS_SM_HIGH: begin
				kp1_d = pk[23:8];
				ki1_d = pi[19:4];
			end
			`ATS_SM_ANG: begin
				// A zero angle would divide by zero, so the gains are then held.
				if (ang_q != 16'h0) begin
					kp1_d = 16'((32'(iner_q) * 32'(damp_q)) / 32'(ang_q));
					ki1_d = 16'((32'(iner_q) << 4) / 32'(ang_q));
				end
			end
			default: ;
		endcase
		// Gain set choice and the times-16 option act on the live gains.
		kpa_d = {4'h0, ctrl_q[`ATS_F_GSET] ? kp2_q : kp1_q};
		if (sm == `ATS_SM_X16) begin
			kpa_d = {kpa_d[15:0], 4'h0};
		end
		// Test sequencer.
		case (st_q)
			ats_pkg::ST_IDLE: begin
				cnt_d = 32'h0; revs_d = 4'h0; samp_d = 4'h0; tries_d = 8'h0; cal_d = 1'b0;
				if (go) begin
					case (sel)
						`ATS_SEL_ROT:  st_d = ats_pkg::ST_ROT_SPIN;
						`ATS_SEL_INR:  st_d = ats_pkg::ST_INR_RAMP;
						`ATS_SEL_LOCK: st_d = ats_pkg::ST_LOCK_MEAS;
						default: ;
					endcase
				end
			end
			ats_pkg::ST_ROT_SPIN: begin
				if (rev_pulse) begin
					revs_d = revs_q + 4'h1;
					if (revs_q == `ATS_ROT_REVS - 4'h1) begin
						revs_d = 4'h0;
						st_d = ats_pkg::ST_ROT_MEAS;
						if (!ctrl_q[`ATS_F_SLESS]) begin
							ph_d = ctrl_q[`ATS_F_FBSEL] ? i_fb_angle1 : i_fb_angle0;
						end
					end
				end
			end
			ats_pkg::ST_ROT_MEAS: begin
				if (i_meas_done) begin
					// Loaded once per test, so user edits of these gains survive until the next rotating test.
					if (!cal_q) begin
						ckp_d = res_d[`ATS_RES_LS];
						cki_d = res_d[`ATS_RES_RS];
						cal_d = 1'b1;
					end
					cnt_d = 32'h0;
					st_d = ats_pkg::ST_ROT_WAIT;
				end
			end
			ats_pkg::ST_ROT_WAIT: begin
				cnt_d = cnt_q + 32'h1;
				if (cnt_q >= 32'(COG_WAIT_CYC) - 32'h1) begin
					st_d = ats_pkg::ST_ROT_COG;
				end
			end
			ats_pkg::ST_ROT_COG: begin
				if (i_meas_valid && i_meas_idx >= `ATS_RES_COG && i_meas_idx <= `ATS_RES_COG_END
					&& samp_q != `ATS_COG_SAMPLES) begin
					samp_d = samp_q + 4'h1;
				end
				if (rev_pulse) begin
					revs_d = 4'h1;
				end
				if (revs_q != 4'h0 && samp_q == `ATS_COG_SAMPLES) begin
					st_d = ats_pkg::ST_INHIBIT;
				end
			end
			ats_pkg::ST_INR_RAMP: begin
				cnt_d = cnt_q + 32'h1;
				if (i_at_speed) begin
					cnt_d = 32'h0;
					st_d = ats_pkg::ST_INR_HOLD;
				end else if (cnt_q >= 32'(RAMP_TMO_CYC) - 32'h1) begin
					cnt_d = 32'h0;
					tries_d = tries_q + 8'h1;
					if (tries_q >= 8'(INR_TRIES) - 8'h1) begin
						st_d = ats_pkg::ST_TRIP;
					end
				end
			end
			ats_pkg::ST_INR_HOLD: begin
				cnt_d = cnt_q + 32'h1;
				if (cnt_q >= 32'(INR_HOLD_CYC) - 32'h1) begin
					st_d = ats_pkg::ST_INR_MEAS;
				end
			end
			ats_pkg::ST_INR_MEAS, ats_pkg::ST_LOCK_MEAS: begin
				if (i_meas_done) begin
					st_d = ats_pkg::ST_INHIBIT;
				end
			end
			ats_pkg::ST_INHIBIT, ats_pkg::ST_TRIP: begin
				if (dis) begin
					st_d = ats_pkg::ST_IDLE;
				end
			end
			default: st_d = ats_pkg::ST_IDLE;
		endcase
		// Losing enable mid-test abandons the test without a trip.
		if (dis && st_q != ats_pkg::ST_IDLE && st_q != ats_pkg::ST_INHIBIT &&
			st_q != ats_pkg::ST_TRIP) begin
			st_d = ats_pkg::ST_IDLE;
		end
		rated_d = st_d == ats_pkg::ST_ROT_SPIN || st_d == ats_pkg::ST_ROT_COG ||
			st_d == ats_pkg::ST_LOCK_MEAS;
		rotate_d = st_d == ats_pkg::ST_ROT_SPIN || st_d == ats_pkg::ST_ROT_COG;
		ramp_d = st_d == ats_pkg::ST_INR_RAMP || st_d == ats_pkg::ST_INR_HOLD ||
			st_d == ats_pkg::ST_INR_MEAS;
		mreq_d = st_d == ats_pkg::ST_ROT_MEAS || st_d == ats_pkg::ST_ROT_COG ||
			st_d == ats_pkg::ST_INR_MEAS || st_d == ats_pkg::ST_LOCK_MEAS;
		kind_d = (st_d == ats_pkg::ST_ROT_COG) ? 2'h1 : (st_d == ats_pkg::ST_INR_MEAS) ? 2'h2 :
			(st_d == ats_pkg::ST_LOCK_MEAS) ? 2'h3 : 2'h0;
		trip_d = st_d == ats_pkg::ST_TRIP;
		inh_d = st_d == ats_pkg::ST_INHIBIT || st_d == ats_pkg::ST_TRIP;
		// Normal running is refused while inhibited or while a test is selected.
		allow_d = st_d == ats_pkg::ST_IDLE && go && sel != `ATS_SEL_ROT &&
			sel != `ATS_SEL_INR && sel != `ATS_SEL_LOCK;
	end

	// Registers only.
	always_ff @(posedge i_clock) begin
		if (!i_rst_n) begin
			st_q <= ats_pkg::ST_IDLE;
			cnt_q <= 32'h0; revs_q <= 4'h0; samp_q <= 4'h0; tries_q <= 8'h0; cal_q <= 1'b0;
			ctrl_q <= `ATS_CTRL_RST; rspd_q <= `ATS_RSPD_RST;
			kp1_q <= `ATS_KP_RST; ki1_q <= `ATS_KI_RST; kp2_q <= `ATS_KP_RST; ki2_q <= `ATS_KI_RST;
			bw_q <= `ATS_BW_RST; ang_q <= `ATS_ANG_RST; damp_q <= `ATS_DAMP_RST;
			iner_q <= 16'h0; ckp_q <= 16'h0; cki_q <= 16'h0; ph_q <= 16'h0;
			for (int i = 0; i < `ATS_RES_N; i++) begin
				res_q[i] <= 16'h0;
			end
			rdy_q <= 1'b0; err_q <= 1'b0; o_prdata <= 32'h0;
			o_rated_current <= 1'b0; o_rotate <= 1'b0; o_direction <= 1'b0; o_ramp_run <= 1'b0;
			o_speed_target <= 16'h0; o_meas_req <= 1'b0; o_meas_kind <= 2'h0; o_trip <= 1'b0;
			o_inhibit <= 1'b0; o_run_allow <= 1'b0; o_kp_active <= 20'h0; o_ki_active <= 16'h0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d; revs_q <= revs_d; samp_q <= samp_d; tries_q <= tries_d; cal_q <= cal_d;
			ctrl_q <= ctrl_d; rspd_q <= rspd_d;
			kp1_q <= kp1_d; ki1_q <= ki1_d; kp2_q <= kp2_d; ki2_q <= ki2_d;
			bw_q <= bw_d; ang_q <= ang_d; damp_q <= damp_d;
			iner_q <= iner_d; ckp_q <= ckp_d; cki_q <= cki_d; ph_q <= ph_d;
			res_q <= res_d;
			rdy_q <= rdy_d; err_q <= err_d; o_prdata <= prdata_d;
			o_rated_current <= rated_d; o_rotate <= rotate_d; o_direction <= ctrl_d[`ATS_F_DIR];
			o_ramp_run <= ramp_d; o_speed_target <= {2'h0, rspd_d[15:2]};
			o_meas_req <= mreq_d; o_meas_kind <= kind_d; o_trip <= trip_d;
			o_inhibit <= inh_d; o_run_allow <= allow_d;
			o_kp_active <= kpa_d;
			o_ki_active <= ctrl_q[`ATS_F_GSET] ? ki2_q : ki1_q;
		end
	end

	// Flop-driven views of stored registers.
	assign o_pready = rdy_q;
	assign o_pslverr = err_q;
	assign o_cur_kp = ckp_q;
	assign o_cur_ki = cki_q;
	assign o_phase_angle = ph_q;
endmodule

// file: ats_params.svh
`ifndef ATS_PARAMS_SVH
`define ATS_PARAMS_SVH
// Clock rate and documented times.
`define ATS_CLK_HZ       20000000
`define ATS_COG_WAIT_S   5
`define ATS_INR_HOLD_S   60
`define ATS_RAMP_TMO_S   10
`define ATS_INR_TRIES    3
`define ATS_ROT_REVS     4'h2
`define ATS_COG_SAMPLES  4'h8
// Autotune selector codes.
`define ATS_SEL_ROT      3'h2
`define ATS_SEL_INR      3'h3
`define ATS_SEL_LOCK     3'h4
// Speed gain setup methods and their fixed bandwidths in Hz.
`define ATS_SM_BW        3'h1
`define ATS_SM_ANG       3'h2
`define ATS_SM_X16       3'h3
`define ATS_SM_LOW       3'h4
`define ATS_SM_STD       3'h5
`define ATS_SM_HIGH      3'h6
`define ATS_BW_LOW       16'h0005
`define ATS_BW_STD       16'h0019
`define ATS_BW_HIGH      16'h0064
`define ATS_DAMP_UNITY   16'h0100
// Register byte offsets.
`define ATS_A_CTRL       8'h00
`define ATS_A_STAT       8'h04
`define ATS_A_RSPD       8'h08
`define ATS_A_KP1        8'h0c
`define ATS_A_KI1        8'h10
`define ATS_A_KP2        8'h14
`define ATS_A_KI2        8'h18
`define ATS_A_BW         8'h1c
`define ATS_A_ANG        8'h20
`define ATS_A_DAMP       8'h24
`define ATS_A_INER       8'h28
`define ATS_A_CKP        8'h2c
`define ATS_A_CKI        8'h30
`define ATS_A_PHASE      8'h34
`define ATS_RES_W_LO     6'h10
`define ATS_RES_W_HI     6'h28
// Control register fields.
`define ATS_F_SEL        2:0
`define ATS_F_EN         3
`define ATS_F_DIR        4
`define ATS_F_SLESS      5
`define ATS_F_FBSEL      6
`define ATS_F_GSET       7
`define ATS_F_SM         10:8
`define ATS_F_CWDIS      11
// Result slots.
`define ATS_RES_RS       5'h00
`define ATS_RES_LS       5'h01
`define ATS_RES_COG      5'h0d
`define ATS_RES_COG_END  5'h14
`define ATS_RES_INER     5'h15
`define ATS_RES_N        24
// Reset values.
`define ATS_CTRL_RST     12'h008
`define ATS_RSPD_RST     16'h0bb8
`define ATS_KP_RST       16'h0100
`define ATS_KI_RST       16'h0080
`define ATS_BW_RST       16'h0019
`define ATS_ANG_RST      16'h0100
`define ATS_DAMP_RST     16'h0100
`endif

// file: ats_pkg.sv
package ats_pkg;
	typedef enum logic [3:0] {
		ST_IDLE, ST_ROT_SPIN, ST_ROT_MEAS, ST_ROT_WAIT, ST_ROT_COG,
		ST_INR_RAMP, ST_INR_HOLD, ST_INR_MEAS, ST_LOCK_MEAS, ST_INHIBIT, ST_TRIP
	} ats_state_t;
	typedef logic [15:0] ats_word_t;
endpackage

// file: ats_sequencer_properties.sv
`timescale 1ns/1ps
// Port-level checks on the autotune sequencer; it only watches, never drives.
module ats_sequencer_properties (
	// Clock and reset.
	input wire logic        i_clock,
	input wire logic        i_rst_n,
	// Bus handshake.
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        o_pready,
	// Drive commands and status.
	input wire logic        o_rated_current,
	input wire logic        o_rotate,
	input wire logic        o_ramp_run,
	input wire logic [15:0] o_speed_target,
	input wire logic        o_meas_req,
	input wire logic [1:0]  o_meas_kind,
	input wire logic        o_trip,
	input wire logic        o_inhibit,
	input wire logic        o_run_allow
);
	// One clock domain, so every check shares it and sleeps through reset.
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	// A setup cycle followed by the first access cycle opens a transfer.
	sequence s_open; i_psel && !i_penable ##1 i_psel && i_penable; endsequence
	// The answer comes after exactly one wait state and stands one cycle.
	sequence s_answer; !o_pready ##1 o_pready ##1 !o_pready; endsequence
	property p_apb_wait; s_open |-> s_answer; endproperty
	a_apb_wait: assert property (p_apb_wait) else $error("bus answer timing wrong");
	property p_rot; o_rotate |-> o_rated_current && !o_ramp_run; endproperty
	a_rot: assert property (p_rot) else $error("rotation without rated current");
	property p_still; o_meas_req && o_meas_kind == 2'h0 |-> !o_rotate && !o_rated_current; endproperty
	a_still: assert property (p_still) else $error("standstill test moves motor");
	property p_cog; o_meas_req && o_meas_kind == 2'h1 |-> o_rotate; endproperty
	a_cog: assert property (p_cog) else $error("cogging capture without turn");
	property p_inr; o_ramp_run |-> o_speed_target == 16'h02ee && !o_rated_current; endproperty
	a_inr: assert property (p_inr) else $error("inertia ramp target wrong");
	property p_lock; o_meas_req && o_meas_kind == 2'h3 |-> o_rated_current && !o_rotate; endproperty
	a_lock: assert property (p_lock) else $error("locked test drive wrong");
	property p_trip; o_trip |-> o_inhibit && !o_rated_current && !o_ramp_run; endproperty
	a_trip: assert property (p_trip) else $error("trip leaves drive active");
	property p_inh; o_inhibit |-> !o_run_allow && !o_meas_req; endproperty
	a_inh: assert property (p_inh) else $error("inhibit allows running");
	property p_done; $rose(o_inhibit) && !o_trip |-> $past(o_meas_req); endproperty
	a_done: assert property (p_done) else $error("inhibit without finished test");
endmodule

bind ats_sequencer ats_sequencer_properties u_props (
	.i_clock(i_clock), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
	.o_pready(o_pready), .o_rated_current(o_rated_current), .o_rotate(o_rotate),
	.o_ramp_run(o_ramp_run), .o_speed_target(o_speed_target), .o_meas_req(o_meas_req),
	.o_meas_kind(o_meas_kind), .o_trip(o_trip), .o_inhibit(o_inhibit), .o_run_allow(o_run_allow));

// file: ats_motor_model.sv
`timescale 1ns/1ps
// Behavioural motor, shaft sensor and measurement engine facing the sequencer.
module ats_motor_model (
	// Clock and drive commands.
	input  wire logic        i_clock,
	input  wire logic        i_rotate,
	input  wire logic        i_meas_req,
	input  wire logic [1:0]  i_meas_kind,
	input  wire logic        i_ramp_run,
	// Cycles to reach speed, and a load that never gets there.
	input  wire logic [7:0]  i_speed_dly,
	input  wire logic        i_stall,
	// Returns to the drive.
	output logic             o_elec_rev = 1'b0,
	output logic             o_meas_valid = 1'b0,
	output logic      [4:0]  o_meas_idx = 5'h00,
	output logic      [15:0] o_meas_data = 16'h0000,
	output logic             o_meas_done = 1'b0,
	output logic             o_at_speed = 1'b0
);
	logic [2:0] rev_q = 3'h0;
	logic [3:0] step_q = 4'h0;
	logic [7:0] spd_q = 8'h00;
	logic [4:0] base;
	logic [4:0] idx;
	logic       hit;
	// Each kind of measurement fills eight result slots from its own base; the runs of kinds 0, 3 and 1 overlap.
	always_comb begin
		case (i_meas_kind)
			2'h0: base = 5'h00;
			2'h1: base = 5'h0d;
			2'h2: base = 5'h15;
			default: base = 5'h06;
		endcase
		idx = base + {1'b0, step_q} - 5'h02;
		hit = i_meas_req && step_q >= 4'h2 && step_q < 4'ha;
	end
	// The shaft turns only while driven; a held rotor never reports a turn.
	always @(posedge i_clock) begin
		rev_q <= i_rotate ? rev_q + 3'h1 : 3'h0;
		o_elec_rev <= i_rotate & rev_q[2];
	end
	// Results follow the request, then a done pulse; idle lines flip so stale data shows.
	always @(posedge i_clock) begin
		step_q <= !i_meas_req ? 4'h0 : (step_q == 4'hf ? step_q : step_q + 4'h1);
		o_meas_valid <= hit;
		o_meas_idx <= hit ? idx : ~o_meas_idx;
		o_meas_data <= hit ? {11'h008, idx} : ~o_meas_data;
		o_meas_done <= i_meas_req && step_q == 4'ha;
	end
	// A stalled load never reaches speed, which forces every retry.
	always @(posedge i_clock) begin
		spd_q <= !i_ramp_run ? 8'h00 : (spd_q == 8'hff ? spd_q : spd_q + 8'h01);
		o_at_speed <= i_ramp_run && !i_stall && spd_q >= i_speed_dly;
	end
endmodule

// file: ats_sequencer_test.sv
`timescale 1ns/1ps
// Self-checking bench for the autotune sequencer.
module ats_sequencer_test;
	logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        en_pin = 1'b0, run_pin = 1'b0, stall = 1'b0, err, pready, pslv;
	logic        rev, mv, mdone, atspd, rc, rot, dir, ramp, mreq, trip, inh, rallow;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [4:0]  midx;
	logic [1:0]  mkind;
	logic [15:0] mdata, spd, ckp, cki, phase, kia;
	// Feedback angles come from bench variables so the phase path is not a tied constant.
	logic [15:0] fba0 = 16'h1111, fba1 = 16'h2222;
	logic [19:0] kpa;
	int          num_errors = 0, check_count = 0;
	wire  [3:0]  flags = {mreq && mkind == 2'h3, trip, rot, inh};
	// Short counts keep the run brief.
	ats_sequencer #(.COG_WAIT_CYC(20), .INR_HOLD_CYC(30), .RAMP_TMO_CYC(40), .INR_TRIES(3)) u_dut (
		.i_clock(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
		.i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
		.o_pslverr(pslv), .i_enable_pin(en_pin), .i_run_pin(run_pin), .i_elec_rev_pin(rev),
		.i_meas_valid(mv), .i_meas_idx(midx), .i_meas_data(mdata), .i_meas_done(mdone),
		.i_at_speed(atspd), .i_fb_angle0(fba0), .i_fb_angle1(fba1),
		.o_rated_current(rc), .o_rotate(rot), .o_direction(dir), .o_ramp_run(ramp),
		.o_speed_target(spd), .o_meas_req(mreq), .o_meas_kind(mkind), .o_trip(trip),
		.o_inhibit(inh), .o_run_allow(rallow), .o_kp_active(kpa), .o_ki_active(kia),
		.o_cur_kp(ckp), .o_cur_ki(cki), .o_phase_angle(phase));
	ats_motor_model u_motor (.i_clock(clk), .i_rotate(rot), .i_meas_req(mreq),
		.i_meas_kind(mkind), .i_ramp_run(ramp), .i_speed_dly(8'h0a), .i_stall(stall),
		.o_elec_rev(rev), .o_meas_valid(mv), .o_meas_idx(midx), .o_meas_data(mdata),
		.o_meas_done(mdone), .o_at_speed(atspd));
	initial forever #25 clk = ~clk;
	task summarize;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	// A used-up bound is a mismatch and ends the run at once.
	task tmo(input int n, input int lim);
		if (n >= lim) begin
			num_errors++;
			$display("BAD wait exp %0d got %0d", lim, n);
			summarize();
		end
	endtask
	task wait_sig(input int k, input logic v, input int lim);
		int n;
		n = 0;
		while (flags[k] !== v && n < lim) begin
			@(posedge clk);
			n++;
		end
		tmo(n, lim);
	endtask
	// One transfer; the master never assumes how long the slave takes.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslv;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
		tmo(n, 20);
	endtask
	task wait_kp(input logic [19:0] ep, input logic [15:0] ei);
		int n;
		n = 0;
		while ((kpa !== ep || kia !== ei) && n < 8) begin
			@(posedge clk);
			n++;
		end
		chk("kp active", {12'h0, ep}, {12'h0, kpa});
		chk("ki active", {16'h0, ei}, {16'h0, kia});
	endtask
	task t_regs;
		logic [7:0]  ra [4];
		logic [31:0] rv [4];
		ra = '{8'h00, 8'h08, 8'h0c, 8'h10};
		rv = '{32'h008, 32'hbb8, 32'h100, 32'h080};
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, ra[i], 32'h0);
			chk("reset value", rv[i], rd);
		end
		apb(1'b0, 8'hfc, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
	endtask
	task t_rot;
		apb(1'b1, 8'h00, 32'h01a);
		wait_sig(1, 1'b1, 100);
		chk("direction", 32'h1, {31'h0, dir});
		wait_sig(0, 1'b1, 800);
		chk("current kp", 32'h0101, {16'h0, ckp});
		chk("current ki", 32'h0100, {16'h0, cki});
		chk("phase angle", 32'h1111, {16'h0, phase});
		apb(1'b0, 8'h74, 32'h0);
		chk("cogging slot", 32'h010d, rd);
		apb(1'b1, 8'h2c, 32'h0abc);
		chk("user current kp", 32'h0abc, {16'h0, ckp});
		en_pin <= 1'b0;
		wait_sig(0, 1'b0, 20);
		apb(1'b1, 8'h00, 32'h008);
		en_pin <= 1'b1;
	endtask
	// A stalled load must trip; a free one must store its inertia.
	task t_inr(input logic s);
		stall <= s;
		apb(1'b1, 8'h00, 32'h00b);
		wait_sig(s ? 2 : 0, 1'b1, 800);
		chk("trip", {31'h0, s}, {31'h0, trip});
		apb(1'b0, 8'h28, 32'h0);
		chk("inertia", s ? 32'h0 : 32'h0115, rd);
		apb(1'b1, 8'h00, {20'h0, s, 11'h003});
		wait_sig(0, 1'b0, 20);
		apb(1'b1, 8'h00, 32'h008);
	endtask
	task t_gain;
		logic [2:0]  m [4];
		logic [7:0]  b [4];
		logic [47:0] p;
		logic [47:0] q;
		m = '{3'h4, 3'h5, 3'h6, 3'h1};
		b = '{8'h05, 8'h19, 8'h64, 8'h19};
		apb(1'b1, 8'h0c, 32'h0123);
		apb(1'b1, 8'h10, 32'h0045);
		apb(1'b1, 8'h14, 32'h0200);
		apb(1'b1, 8'h18, 32'h0066);
		wait_kp(20'h00123, 16'h0045);
		chk("no test", 32'h0, {31'h0, rot | inh});
		apb(1'b1, 8'h00, 32'h088);
		wait_kp(20'h00200, 16'h0066);
		apb(1'b1, 8'h00, 32'h388);
		wait_kp(20'h02000, 16'h0066);
		for (int i = 0; i < 4; i++) begin
			p = 48'h115 * b[i];
			q = p * b[i];
			apb(1'b1, 8'h00, {21'h0, m[i], 8'h08});
			wait_kp({4'h0, p[15:0]}, q[19:4]);
		end
		apb(1'b1, 8'h00, 32'h208);
		wait_kp(20'h00115, 16'h0011);
		apb(1'b1, 8'h00, 32'h008);
	endtask
	task t_lock;
		apb(1'b1, 8'h00, 32'h00c);
		wait_sig(3, 1'b1, 100);
		chk("locked current", 32'h1, {31'h0, rc});
		wait_sig(0, 1'b1, 400);
		apb(1'b0, 8'h58, 32'h0);
		chk("rated load lq", 32'h0106, rd);
		en_pin <= 1'b0;
		wait_sig(0, 1'b0, 20);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_regs();
		en_pin <= 1'b1;
		run_pin <= 1'b1;
		t_rot();
		t_inr(1'b1);
		t_inr(1'b0);
		t_gain();
		t_lock();
		summarize();
	end
	// A hung run is cut short here.
	initial begin
		repeat (100000) @(posedge clk);
		tmo(1, 1);
	end
endmodule
